// File: src/serial_port_consts.vh
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// ----------------------------------------
// Register offsets (byte address on the plain port)
// ----------------------------------------
`define ADDR_SERIAL_CONTROL 8'h00
`define ADDR_SERIAL_BUFFER 8'h04
`define ADDR_POWER_CONTROL 8'h08
`define ADDR_BAUD_RELOAD 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_RECEIVE_DONE 0
`define BIT_TRANSMIT_DONE 1
`define BIT_RECEIVED_NINTH 2
`define BIT_TRANSMIT_NINTH 3
`define BIT_RECEIVE_ENABLE 4
`define BIT_MULTIPROCESSOR 5
`define BIT_MODE_LOW 6
`define BIT_MODE_HIGH 7
`define BIT_FE_VIEW 6
`define BIT_BAUD_DOUBLER 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RESET_SERIAL_CONTROL 8'h00
`define RESET_POWER_CONTROL 8'h00
`define RESET_BAUD_RELOAD 16'h0000
`define SLICES_PER_BIT 16
`define SAMPLE_FIRST 4'h7
`define SAMPLE_SECOND 4'h8
`define SAMPLE_THIRD 4'h9
`define MODE2_SLOW_DIVIDE 16'h0004
`define MODE2_FAST_DIVIDE 16'h0002

`endif

// File: src/baud_tick_gen.v
`timescale 1ns/1ps
`include "serial_port_consts.vh"

// Makes the sixteen-times-bit-rate slice enable. Timer modes use a reload
// counter as the overflow source; mode 2 divides the system clock.
module baud_tick_gen #(
	parameter RELOAD_WIDTH = 16
) (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire [1:0] mode_i,
	input wire doubler_i,
	input wire [RELOAD_WIDTH-1:0] reload_i,
	output reg slice_o
);
	reg [RELOAD_WIDTH-1:0] count;
	reg half;
	wire overflow;
	wire [RELOAD_WIDTH-1:0] limit;
	wire [15:0] prescale;
	wire [RELOAD_WIDTH+15:0] prescale_wide;

	// Mode 2: a fixed prescale stands in for the oscillator ratio
	assign prescale = doubler_i ? `MODE2_FAST_DIVIDE - 16'h0001 : `MODE2_SLOW_DIVIDE - 16'h0001;
	// Widen before cutting so any reload width takes the prescale cleanly
	assign prescale_wide = {{RELOAD_WIDTH{1'b0}}, prescale};
	assign limit = (mode_i == 2'b10) ? prescale_wide[RELOAD_WIDTH-1:0] : reload_i;
	assign overflow = (count >= limit);

	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= {RELOAD_WIDTH{1'b0}};
			half <= 1'b0;
			slice_o <= 1'b0;
		end else begin
			slice_o <= 1'b0;
			if (overflow) begin
				count <= {RELOAD_WIDTH{1'b0}};
				half <= ~half;
				// Doubler off halves the rate: 1/32 instead of 1/16
				if (doubler_i || half || mode_i == 2'b10)
					slice_o <= 1'b1;
			end else begin
				count <= count + {{(RELOAD_WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // baud_tick_gen

// File: src/serial_rx.v
`timescale 1ns/1ps
`include "serial_port_consts.vh"

// Receiver: edge hunt, slice counter reset, majority vote per bit.
module serial_rx (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire slice_i,
	input wire rx_i,
	input wire enable_i,
	input wire nine_bit_i,
	output reg done_o,
	output reg [7:0] data_o,
	output reg ninth_o,
	output reg stop_o
);
	localparam IDLE = 1'b0;
	localparam BUSY = 1'b1;

	reg state;
	reg prev;
	reg [3:0] slice;
	reg [3:0] bit_index;
	reg [2:0] votes;
	reg [9:0] shift;
	wire vote;
	wire [3:0] last_index;

	assign vote = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);
	assign last_index = nine_bit_i ? 4'hA : 4'h9;

	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= IDLE;
			prev <= 1'b1;
			slice <= 4'h0;
			bit_index <= 4'h0;
			votes <= 3'b111;
			shift <= 10'h000;
			done_o <= 1'b0;
			data_o <= 8'h00;
			ninth_o <= 1'b0;
			stop_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (slice_i) begin
				prev <= rx_i;
				case (state)
				IDLE: begin
					if (enable_i && prev && !rx_i) begin
						state <= BUSY;
						slice <= 4'h0;
						bit_index <= 4'h0;
					end
				end
				BUSY: begin
					slice <= slice + 4'h1;
					if (slice == `SAMPLE_FIRST)
						votes[0] <= rx_i;
					if (slice == `SAMPLE_SECOND)
						votes[1] <= rx_i;
					if (slice == `SAMPLE_THIRD) begin
						votes[2] <= rx_i;
					end
					if (slice == `SAMPLE_THIRD + 4'h1) begin
						bit_index <= bit_index + 4'h1;
						shift <= {vote, shift[9:1]};
						if (bit_index == 4'h0 && vote) begin
							state <= IDLE;
						end else if (bit_index == last_index) begin
							// Stop bit middle reached: back to edge hunt
							state <= IDLE;
							done_o <= 1'b1;
							stop_o <= vote;
							if (nine_bit_i) begin
								// Ninth bit sits above the data byte, start bit below it
								data_o <= shift[8:1];
								ninth_o <= shift[9];
							end else begin
								data_o <= shift[9:2];
								ninth_o <= vote;
							end
						end
					end
				end
				default: state <= IDLE;
				endcase
			end
		end
	end
endmodule // serial_rx

// File: src/serial_port.v
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "serial_port_consts.vh"

module serial_port #(
	parameter RELOAD_WIDTH = 16
) (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	input wire rxd_i,
	output reg txd_o,
	output reg mode_zero_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] serial_control;
	reg framing_error_flag;
	reg mode_select_high;
	reg [7:0] power_control;
	reg [RELOAD_WIDTH-1:0] baud_reload;
	reg [7:0] serial_buffer;
	reg rx_meta;
	reg rx_sync;
	wire slice;
	wire rx_done;
	wire [7:0] rx_data;
	wire rx_ninth;
	wire rx_stop;
	wire [1:0] mode;
	wire nine_bit;
	wire fe_view;
	wire load_ok;
	wire wr_control;
	wire wr_buffer;
	wire [RELOAD_WIDTH+15:0] reload_ext;

	assign mode = {mode_select_high, serial_control[`BIT_MODE_LOW]};
	assign nine_bit = mode_select_high;
	assign fe_view = power_control[`BIT_FE_VIEW];
	assign wr_control = wr_i && addr_i == `ADDR_SERIAL_CONTROL;
	assign wr_buffer = wr_i && addr_i == `ADDR_SERIAL_BUFFER;
	// Zero-extend first so any reload width reads back cleanly
	assign reload_ext = {16'h0000, baud_reload};
	assign load_ok = rx_done && !serial_control[`BIT_RECEIVE_DONE] &&
		(!serial_control[`BIT_MULTIPROCESSOR] || rx_stop);

	// ----------------------------------------
	// Receive pin synchroniser
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end else begin
			rx_meta <= rxd_i;
			rx_sync <= rx_meta;
		end
	end

	baud_tick_gen #(
		.RELOAD_WIDTH(RELOAD_WIDTH)
	) u_baud (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.mode_i(mode),
		.doubler_i(power_control[`BIT_BAUD_DOUBLER]),
		.reload_i(baud_reload),
		.slice_o(slice)
	);

	serial_rx u_rx (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.slice_i(slice),
		.rx_i(rx_sync),
		.enable_i(serial_control[`BIT_RECEIVE_ENABLE] && mode != 2'b00),
		.nine_bit_i(nine_bit),
		.done_o(rx_done),
		.data_o(rx_data),
		.ninth_o(rx_ninth),
		.stop_o(rx_stop)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	reg tx_busy;
	reg tx_pending;
	reg [3:0] tx_slice;
	reg [3:0] tx_bits_left;
	reg [10:0] tx_shift;
	reg tx_done_pulse;
	wire tx_rollover;

	// Transmit slice counter runs free so bit edges follow rollovers
	assign tx_rollover = slice && tx_slice == 4'hF;

	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_slice <= 4'h0;
			tx_busy <= 1'b0;
			tx_pending <= 1'b0;
			tx_bits_left <= 4'h0;
			tx_shift <= 11'h7FF;
			txd_o <= 1'b1;
			tx_done_pulse <= 1'b0;
		end else begin
			tx_done_pulse <= 1'b0;
			if (slice)
				tx_slice <= tx_slice + 4'h1;
			if (wr_buffer && mode != 2'b00) begin
				tx_pending <= 1'b1;
				// Frame: stop, ninth (or stop), data, start
				if (nine_bit)
					tx_shift <= {1'b1, serial_control[`BIT_TRANSMIT_NINTH], wdata_i[7:0], 1'b0};
				else
					tx_shift <= {1'b1, 1'b1, wdata_i[7:0], 1'b0};
				tx_bits_left <= nine_bit ? 4'hB : 4'hA;
			end else if (tx_rollover) begin
				if (tx_pending || tx_busy) begin
					tx_pending <= 1'b0;
					txd_o <= tx_shift[0];
					tx_shift <= {1'b1, tx_shift[10:1]};
					tx_bits_left <= tx_bits_left - 4'h1;
					// Done is flagged as the stop bit goes out, not one bit later
					tx_busy <= (tx_bits_left != 4'h1);
					if (tx_bits_left == 4'h1)
						tx_done_pulse <= 1'b1;
				end else begin
					txd_o <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Control, flags and register access
	// ----------------------------------------
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_control <= `RESET_SERIAL_CONTROL;
			mode_select_high <= 1'b0;
			framing_error_flag <= 1'b0;
			power_control <= `RESET_POWER_CONTROL;
			baud_reload <= `RESET_BAUD_RELOAD;
			serial_buffer <= 8'h00;
			mode_zero_o <= 1'b1;
		end else begin
			mode_zero_o <= (mode == 2'b00);
			if (wr_control) begin
				serial_control <= wdata_i[7:0];
				if (fe_view)
					framing_error_flag <= wdata_i[`BIT_MODE_HIGH];
				else
					mode_select_high <= wdata_i[`BIT_MODE_HIGH];
			end
			if (wr_i && addr_i == `ADDR_POWER_CONTROL)
				power_control <= wdata_i[7:0];
			if (wr_i && addr_i == `ADDR_BAUD_RELOAD)
				baud_reload <= wdata_i[RELOAD_WIDTH-1:0];
			// Hardware sets win over a same-cycle software clear
			if (rx_done && !rx_stop)
				framing_error_flag <= 1'b1;
			if (tx_done_pulse)
				serial_control[`BIT_TRANSMIT_DONE] <= 1'b1;
			if (load_ok) begin
				serial_buffer <= rx_data;
				serial_control[`BIT_RECEIVED_NINTH] <= rx_ninth;
				serial_control[`BIT_RECEIVE_DONE] <= 1'b1;
			end
		end
	end

	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
			`ADDR_SERIAL_CONTROL: rdata_o <= {8'h00, fe_view ? framing_error_flag : mode_select_high,
				serial_control[6:0]};
			`ADDR_SERIAL_BUFFER: rdata_o <= {8'h00, serial_buffer};
			`ADDR_POWER_CONTROL: rdata_o <= {8'h00, power_control};
			`ADDR_BAUD_RELOAD: rdata_o <= reload_ext[15:0];
			default: rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end
endmodule // serial_port

// File: testbench/serial_port_monitor.sv
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_monitor (
	input wire clk_sys_i,
	input wire arst_n_i,
	input wire [7:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [15:0] rdata_o,
	input wire rxd_i,
	input wire txd_o,
	input wire mode_zero_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);
	// Sticky: a start bit with no buffer write ever seen is spurious
	reg armed;
	wire wb = wr_i && addr_i == `ADDR_SERIAL_BUFFER;
	wire wc = wr_i && addr_i == `ADDR_SERIAL_CONTROL;
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			armed <= 1'b0;
		else if (wb)
			armed <= 1'b1;
	end
	property p_rdata_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
	property p_unmapped; rd_i && addr_i == 8'h10 |=> rdata_o == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_mode_set; wc && wdata_i[6] |-> ##[1:2] !mode_zero_o; endproperty
	a_mode_set: assert property (p_mode_set) else $error("mode bits not taken");
	property p_mode0_quiet; mode_zero_o |-> txd_o; endproperty
	a_mode0_quiet: assert property (p_mode0_quiet) else $error("line active in mode 0");
	property p_tx_stable; $changed(txd_o) |=> $stable(txd_o)[*7]; endproperty
	a_tx_stable: assert property (p_tx_stable) else $error("bit shorter than a bit time");
	property p_start_armed; $fell(txd_o) |-> armed; endproperty
	a_start_armed: assert property (p_start_armed) else $error("start bit without write");
	property p_write_hold; wb && txd_o |=> txd_o; endproperty
	a_write_hold: assert property (p_write_hold) else $error("start bit at the write");
	property p_mode0_refuse; wb && mode_zero_o |=> txd_o[*8]; endproperty
	a_mode0_refuse: assert property (p_mode0_refuse) else $error("mode 0 write sent");
	c_frame: cover property ($fell(txd_o));
	c_rx: cover property ($fell(rxd_i));
	c_read: cover property (rd_i && addr_i == `ADDR_SERIAL_BUFFER);
endmodule // serial_port_monitor

// File: testbench/remote_link.sv
`timescale 1ns/1ps
module remote_link (
	input wire clk_sys_i,
	input wire txd_i,
	output reg rxd_o
);
	initial rxd_o = 1'b1;
	task send(input [7:0] d, input nb, input b9, input stp, input integer bc);
		integer i;
		reg [10:0] f;
		begin
			f = nb ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
			for (i = 0; i < 10 + nb; i++) begin
				rxd_o <= f[i];
				repeat (bc) @(posedge clk_sys_i);
			end
			rxd_o <= 1'b1;
		end
	endtask
	task glitch(input integer n);
		rxd_o <= 1'b0;
		repeat (n) @(posedge clk_sys_i);
		rxd_o <= 1'b1;
	endtask
	// Samples mid-bit, so a wrong bit rate shows as wrong bits
	task capture(input nb, input integer bc, output [10:0] f);
		integer i;
		begin
			f = 11'h000;
			@(negedge txd_i);
			repeat (bc / 2) @(posedge clk_sys_i);
			// Returns mid stop bit, so the done flag is read before the bit ends
			for (i = 0; i < 10 + nb; i++) begin
				f[i] = txd_i;
				if (i < 9 + nb)
					repeat (bc) @(posedge clk_sys_i);
			end
		end
	endtask
endmodule // remote_link

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module testbench;
	typedef struct {
		logic [7:0] pwr;
		logic [7:0] ctrl;
		logic [7:0] d;
		integer bc;
	} row_t;
	// Power, control, byte, clocks per bit at reload 0
	row_t rows [4] = '{'{8'h80, 8'h50, 8'hA5, 16}, '{8'h00, 8'h50, 8'h3C, 32},
		'{8'h80, 8'h98, 8'h81, 32}, '{8'h80, 8'hD0, 8'h0F, 16}};
	reg clk_sys_i = 1'b0;
	reg arst_n_i = 1'b0;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg [7:0] addr_i = 8'h00;
	reg [15:0] wdata_i = 16'h0000;
	reg [15:0] r;
	reg [10:0] f;
	reg nb;
	integer err_count = 0;
	integer total_checks = 0;
	integer i;
	wire [15:0] rdata_o;
	wire rxd;
	wire txd_o;
	wire mode_zero_o;
	serial_port #(.RELOAD_WIDTH(16)) u_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd), .txd_o(txd_o),
		.mode_zero_o(mode_zero_o));
	remote_link u_remote (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd));
	initial begin
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	task chk(input [15:0] g, input [15:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= {8'h00, d};
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd_reg(input [7:0] a);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 r = rdata_o;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		chk({txd_o, mode_zero_o}, 2'b11);
		arst_n_i <= 1'b1;
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r, 16'h0000);
		rd_reg(8'h10);
		chk(r, 16'h0000);
		wr_reg(`ADDR_SERIAL_BUFFER, 8'h55);
		repeat (40) @(posedge clk_sys_i);
		chk(txd_o, 1'b1);
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			nb = rows[i].ctrl[7];
			wr_reg(`ADDR_POWER_CONTROL, rows[i].pwr);
			wr_reg(`ADDR_SERIAL_CONTROL, rows[i].ctrl);
			fork
				u_remote.capture(nb, rows[i].bc, f);
				wr_reg(`ADDR_SERIAL_BUFFER, rows[i].d);
			join
			chk(f, nb ? {1'b1, rows[i].ctrl[3], rows[i].d, 1'b0} : {2'b01, rows[i].d, 1'b0});
			rd_reg(`ADDR_SERIAL_CONTROL);
			chk(r[1], 1'b1);
			u_remote.send(~rows[i].d, nb, ~rows[i].ctrl[3], 1'b1, rows[i].bc);
			rd_reg(`ADDR_SERIAL_CONTROL);
			chk(r[2:0], {nb ? ~rows[i].ctrl[3] : 1'b1, 2'b11});
			rd_reg(`ADDR_SERIAL_BUFFER);
			chk(r, {8'h00, ~rows[i].d});
			wr_reg(`ADDR_SERIAL_CONTROL, rows[i].ctrl);
			$display("row %0d done", i);
		end
		wr_reg(`ADDR_POWER_CONTROL, 8'h80);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h50);
		u_remote.glitch(5);
		repeat (40) @(posedge clk_sys_i);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r[0], 1'b0);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h40);
		u_remote.send(8'h11, 1'b0, 1'b0, 1'b1, 16);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r[0], 1'b0);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h50);
		u_remote.send(8'h5A, 1'b0, 1'b0, 1'b1, 16);
		u_remote.send(8'h22, 1'b0, 1'b0, 1'b1, 16);
		rd_reg(`ADDR_SERIAL_BUFFER);
		chk(r, 16'h005A);
		wr_reg(`ADDR_POWER_CONTROL, 8'hC0);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h50);
		u_remote.send(8'h33, 1'b0, 1'b0, 1'b0, 16);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk({r[7], r[0]}, 2'b11);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'hD0);
		u_remote.send(8'h44, 1'b0, 1'b0, 1'b1, 16);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk({r[7], r[0]}, 2'b11);
		wr_reg(`ADDR_POWER_CONTROL, 8'h80);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r[7], 1'b0);
		wr_reg(`ADDR_POWER_CONTROL, 8'hC0);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h50);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r[7], 1'b0);
		wr_reg(`ADDR_SERIAL_CONTROL, 8'h70);
		u_remote.send(8'h66, 1'b0, 1'b0, 1'b0, 16);
		rd_reg(`ADDR_SERIAL_CONTROL);
		chk(r[0], 1'b0);
		wr_reg(`ADDR_BAUD_RELOAD, 8'h01);
		rd_reg(`ADDR_BAUD_RELOAD);
		chk(r, 16'h0001);
		fork
			u_remote.capture(1'b0, 32, f);
			wr_reg(`ADDR_SERIAL_BUFFER, 8'hC3);
		join
		chk(f, {2'b01, 8'hC3, 1'b0});
		$display("awkward tests done");
		print_verdict;
	end
endmodule // testbench
bind serial_port serial_port_monitor u_mon (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
	.mode_zero_o(mode_zero_o));
